// ---- src/auto_exposure_control.sv ----
// Auto-exposure controller: APB registers, metering and damped exposure/gain loop.
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module auto_exposure_control #(
    parameter int FRAME_W = 2048,
    parameter int FRAME_H = 1536
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pixel stream, one pixel per valid cycle
    input wire logic pix_valid,
    input wire logic [7:0] pix_data,
    input wire logic [11:0] pix_x,
    input wire logic [11:0] pix_y,
    input wire logic frame_end,
    // Sensor controls and white-balance region
    output ae_pkg::sensor_ctl_t sensor_ctl,
    output logic sensor_update,
    output ae_pkg::region_t wb_region
);
    // Control and limit registers.
    logic ctl_en, next_ctl_en;
    ae_pkg::priority_t prio, next_prio;
    ae_pkg::lighting_t light, next_light;
    ae_pkg::metering_t meter, next_meter;
    logic [19:0] exp_min, next_exp_min, exp_max, next_exp_max;
    logic [9:0] gain_min, next_gain_min, gain_max, next_gain_max;
    logic [6:0] grey_lo, next_grey_lo, grey_hi, next_grey_hi, grey_tgt, next_grey_tgt;
    logic signed [4:0] bias, next_bias;
    logic [8:0] damp, next_damp;
    ae_pkg::alg_sel_t roi_sel, next_roi_sel;
    ae_pkg::region_t ae_region, next_ae_region, next_wb_region;
    logic [31:0] next_prdata;

    function automatic logic [11:0] scale_dim(input logic [11:0] dim, input logic [8:0] s);
        logic [20:0] p;
        p = 21'(dim) * 21'(s);
        return p[19:8];
    endfunction

    function automatic logic [19:0] clamp20(input logic [20:0] v, input logic [19:0] lo,
                                            input logic [19:0] hi);
        if (v < 21'(lo))
            return lo;
        else if (v > 21'(hi))
            return hi;
        else
            return v[19:0];
    endfunction

    wire logic setup = psel && !penable;
    wire logic wr_en = psel && penable && pwrite;
    wire logic mapped = (paddr[1:0] == 2'h0) && (paddr <= ae_pkg::OFS_MEAN);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    ae_pkg::region_t sel_region;
    assign sel_region = (roi_sel == ae_pkg::ALG_AE) ? ae_region : wb_region; // RULE_13

    logic [7:0] mean_q, next_mean_q;
    logic at_exp_max, at_gain_max;

    always_comb begin
        next_ctl_en = ctl_en;
        next_prio = prio;
        next_light = light;
        next_meter = meter;
        next_exp_min = exp_min;
        next_exp_max = exp_max;
        next_gain_min = gain_min;
        next_gain_max = gain_max;
        next_grey_lo = grey_lo;
        next_grey_hi = grey_hi;
        next_grey_tgt = grey_tgt;
        next_bias = bias;
        next_damp = damp;
        next_roi_sel = roi_sel;
        next_ae_region = ae_region;
        next_wb_region = wb_region;
        next_prdata = prdata;
        if (wr_en && mapped) begin
            case (paddr)
                ae_pkg::OFS_CTRL: begin
                    next_prio = ae_pkg::priority_t'(pwdata[ae_pkg::CTRL_PRIO_BIT]);
                    next_light = ae_pkg::lighting_t'(pwdata[ae_pkg::CTRL_LIGHT_LSB +: 2]);
                    next_meter = ae_pkg::metering_t'(pwdata[ae_pkg::CTRL_METER_LSB +: 2]);
                    next_ctl_en = pwdata[ae_pkg::CTRL_ENABLE_BIT];
                end
                ae_pkg::OFS_EXP_MIN: next_exp_min = pwdata[19:0];
                ae_pkg::OFS_EXP_MAX: next_exp_max = pwdata[19:0];
                ae_pkg::OFS_GAIN_MIN: next_gain_min = pwdata[9:0];
                ae_pkg::OFS_GAIN_MAX: next_gain_max = pwdata[9:0];
                ae_pkg::OFS_GREY: begin
                    next_grey_tgt = pwdata[6:0];
                    next_grey_lo = pwdata[14:8];
                    next_grey_hi = pwdata[22:16];
                end
                ae_pkg::OFS_BIAS: begin
                    // Out-of-range bias saturates at +/-3 stops.
                    if ($signed(pwdata[7:0]) > 8'(ae_pkg::BIAS_MAX))
                        next_bias = ae_pkg::BIAS_MAX; // RULE_07
                    else if ($signed(pwdata[7:0]) < 8'(ae_pkg::BIAS_MIN))
                        next_bias = ae_pkg::BIAS_MIN; // RULE_07
                    else
                        next_bias = pwdata[4:0]; // RULE_07
                end
                ae_pkg::OFS_DAMP: begin
                    next_damp = (pwdata > 32'(ae_pkg::DAMP_ONE)) ? ae_pkg::DAMP_ONE
                        : pwdata[8:0]; // RULE_08
                end
                ae_pkg::OFS_ROI_SEL: begin
                    next_roi_sel = ae_pkg::alg_sel_t'(pwdata[0]); // RULE_13
                    if (pwdata[0])
                        next_ae_region.use_flag = pwdata[8]; // RULE_14
                    else
                        next_wb_region.use_flag = pwdata[8]; // RULE_14
                end
                ae_pkg::OFS_ROI_POS: begin
                    if (roi_sel == ae_pkg::ALG_AE) begin
                        next_ae_region.left = pwdata[11:0]; // RULE_15
                        next_ae_region.top = pwdata[27:16]; // RULE_16
                    end else begin
                        next_wb_region.left = pwdata[11:0]; // RULE_15
                        next_wb_region.top = pwdata[27:16]; // RULE_16
                    end
                end
                ae_pkg::OFS_ROI_SIZE: begin
                    if (roi_sel == ae_pkg::ALG_AE) begin
                        next_ae_region.width = pwdata[11:0]; // RULE_18
                        next_ae_region.height = pwdata[27:16]; // RULE_18
                    end else begin
                        next_wb_region.width = pwdata[11:0]; // RULE_18
                        next_wb_region.height = pwdata[27:16]; // RULE_18
                    end
                end
                default: ;
            endcase
        end
        if (setup) begin
            case (paddr)
                ae_pkg::OFS_CTRL: next_prdata = {26'h0, ctl_en, meter, light, prio};
                ae_pkg::OFS_EXP_MIN: next_prdata = {12'h000, exp_min};
                ae_pkg::OFS_EXP_MAX: next_prdata = {12'h000, exp_max};
                ae_pkg::OFS_GAIN_MIN: next_prdata = {22'h0, gain_min};
                ae_pkg::OFS_GAIN_MAX: next_prdata = {22'h0, gain_max};
                ae_pkg::OFS_GREY: next_prdata = {9'h0, grey_hi, 1'b0, grey_lo, 1'b0, grey_tgt};
                ae_pkg::OFS_BIAS: next_prdata = {{27{bias[4]}}, bias};
                ae_pkg::OFS_DAMP: next_prdata = {23'h0, damp};
                ae_pkg::OFS_ROI_SEL: next_prdata = {23'h0, sel_region.use_flag, 7'h0, roi_sel};
                ae_pkg::OFS_ROI_POS: next_prdata = {4'h0, sel_region.top, 4'h0, sel_region.left};
                ae_pkg::OFS_ROI_SIZE:
                    next_prdata = {4'h0, sel_region.height, 4'h0, sel_region.width};
                ae_pkg::OFS_STATUS: next_prdata = {30'h0, at_gain_max, at_exp_max};
                ae_pkg::OFS_MEAN: next_prdata = {24'h0, mean_q};
                default: next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctl_en <= 1'b0;
            prio <= ae_pkg::PRIO_GAIN;
            light <= ae_pkg::LIGHT_NORMAL;
            meter <= ae_pkg::METER_AVG;
            exp_min <= ae_pkg::EXP_MIN_RST;
            exp_max <= ae_pkg::EXP_MAX_RST;
            gain_min <= ae_pkg::GAIN_MIN_RST;
            gain_max <= ae_pkg::GAIN_MAX_RST;
            grey_lo <= ae_pkg::GREY_LO_RST;
            grey_hi <= ae_pkg::GREY_HI_RST;
            grey_tgt <= ae_pkg::GREY_TGT_RST;
            bias <= '0;
            damp <= ae_pkg::DAMP_RST;
            roi_sel <= ae_pkg::ALG_WB;
            ae_region <= '0;
            wb_region <= '0;
            prdata <= 32'h0;
        end else begin
            ctl_en <= next_ctl_en;
            prio <= next_prio;
            light <= next_light;
            meter <= next_meter;
            exp_min <= next_exp_min;
            exp_max <= next_exp_max;
            gain_min <= next_gain_min;
            gain_max <= next_gain_max;
            grey_lo <= next_grey_lo;
            grey_hi <= next_grey_hi;
            grey_tgt <= next_grey_tgt;
            bias <= next_bias;
            damp <= next_damp;
            roi_sel <= next_roi_sel;
            ae_region <= next_ae_region;
            wb_region <= next_wb_region;
            prdata <= next_prdata;
        end
    end

    // Metering window selection.
    logic [11:0] win_x0, win_y0, win_w, win_h;
    ae_pkg::metering_t eff_meter;
    always_comb begin
        eff_meter = (light == ae_pkg::LIGHT_NORMAL) ? meter : ae_pkg::METER_AVG; // RULE_01
        win_x0 = '0;
        win_y0 = '0;
        win_w = 12'(FRAME_W);
        win_h = 12'(FRAME_H);
        if (ae_region.use_flag) begin
            win_x0 = ae_region.left; // RULE_14
            win_y0 = ae_region.top;
            win_w = ae_region.width;
            win_h = ae_region.height;
        end else begin
            case (eff_meter)
                ae_pkg::METER_SPOT: begin
                    win_w = scale_dim(12'(FRAME_W), ae_pkg::SPOT_SCALE); // RULE_17
                    win_h = scale_dim(12'(FRAME_H), ae_pkg::SPOT_SCALE); // RULE_17
                end
                ae_pkg::METER_PARTIAL: begin
                    win_w = scale_dim(12'(FRAME_W), ae_pkg::PART_SCALE); // RULE_02
                    win_h = scale_dim(12'(FRAME_H), ae_pkg::PART_SCALE); // RULE_02
                end
                default: ;
            endcase
            win_x0 = 12'((FRAME_W - int'(win_w)) / 2);
            win_y0 = 12'((FRAME_H - int'(win_h)) / 2);
        end
    end

    // Per-frame sums; software must not move the window mid-frame.
    logic [31:0] acc, next_acc, cnt, next_cnt;
    logic [19:0] exp_q, next_exp_q;
    logic [9:0] gain_q, next_gain_q;
    logic next_update;
    wire logic in_win = pix_valid && pix_x >= win_x0 && pix_x < win_x0 + win_w
                        && pix_y >= win_y0 && pix_y < win_y0 + win_h;

    always_comb begin
        logic [7:0] mean_now;
        logic [6:0] tgt_pct;
        logic signed [9:0] tgt_raw;
        logic [7:0] tgt_lvl;
        logic signed [9:0] err;
        logic signed [20:0] step;
        tgt_pct = grey_tgt;
        mean_now = (cnt == 0) ? 8'h00 : 8'(acc / cnt); // RULE_19
        tgt_raw = 10'(grey_tgt) + 10'(bias) * 10'(ae_pkg::GREY_PER_THIRD); // RULE_06
        if (tgt_raw < 10'(grey_lo))
            tgt_pct = grey_lo; // RULE_05
        else if (tgt_raw > 10'(grey_hi))
            tgt_pct = grey_hi; // RULE_05
        else
            tgt_pct = tgt_raw[6:0]; // RULE_05
        tgt_lvl = 8'((16'(tgt_pct) * 16'd255) / 16'd100);
        err = 10'(tgt_lvl) - 10'(mean_now);
        step = 21'($signed(err) * $signed({1'b0, damp}));
        next_acc = acc;
        next_cnt = cnt;
        next_mean_q = mean_q;
        next_exp_q = clamp20(21'(exp_q), exp_min, exp_max); // RULE_03
        next_gain_q = (gain_q > gain_max) ? gain_max : gain_q; // RULE_04
        next_gain_q = (next_gain_q < gain_min) ? gain_min : next_gain_q; // RULE_04
        next_update = 1'b0;
        if (in_win) begin
            next_acc = acc + 32'(pix_data);
            next_cnt = cnt + 32'h0000_0001;
        end
        if (frame_end) begin
            next_acc = '0;
            next_cnt = '0;
            next_mean_q = mean_now; // RULE_19
            if (ctl_en) begin
                next_update = 1'b1; // RULE_19
                if (prio == ae_pkg::PRIO_GAIN) begin
                    if (at_exp_max && err > 0)
                        next_gain_q = 10'(clamp20(21'(gain_q) + 21'(step >>> 8),
                                      20'(gain_min), 20'(gain_max))); // RULE_10
                    else begin
                        next_gain_q = (ae_pkg::GAIN_ZERO_DB < gain_min) ? gain_min
                            : ae_pkg::GAIN_ZERO_DB; // RULE_09
                        next_exp_q = clamp20(21'(exp_q) + (step <<< 2),
                                             exp_min, exp_max); // RULE_09
                    end
                end else begin
                    if (at_gain_max && err > 0)
                        next_exp_q = clamp20(21'(exp_q) + (step <<< 2),
                                             exp_min, exp_max); // RULE_12
                    else begin
                        next_exp_q = clamp20(21'(ae_pkg::EXP_FIXED_US), exp_min, exp_max); // RULE_11
                        next_gain_q = 10'(clamp20(21'(gain_q) + 21'(step >>> 8),
                                      20'(gain_min), 20'(gain_max))); // RULE_11
                    end
                end
            end
        end
    end

    assign at_exp_max = (exp_q >= exp_max);
    assign at_gain_max = (gain_q >= gain_max);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            acc <= '0;
            cnt <= '0;
            mean_q <= 8'h00;
            exp_q <= ae_pkg::EXP_FIXED_US;
            gain_q <= ae_pkg::GAIN_ZERO_DB;
            sensor_ctl <= '0;
            sensor_update <= 1'b0;
        end else begin
            acc <= next_acc;
            cnt <= next_cnt;
            mean_q <= next_mean_q;
            exp_q <= next_exp_q;
            gain_q <= next_gain_q;
            sensor_ctl <= '{exposure_us: next_exp_q, gain: next_gain_q};
            sensor_update <= next_update;
        end
    end
endmodule

// ---- src/ae_pkg.sv ----
// Constants and carrier types of the auto-exposure controller.
// How it works
// RULE_01: Metering mode counts only under Normal lighting.
// RULE_02: Partial metering reads a central 11% window.
// RULE_03: Exposure stays within its limits.
// RULE_04: Gain stays within its limits.
// RULE_05: Target percent is clamped to the grey limits.
// RULE_06: Bias offsets the target, positive brighter.
// RULE_07: Bias spans -9..9 thirds, default zero.
// RULE_08: Damping 0.0..1.0 sets settling speed, default 0.2.
// RULE_09: Gain priority holds 0 dB and moves exposure.
// RULE_10: Gain priority moves gain once exposure is at maximum.
// RULE_11: Exposure priority fixes 5 ms and moves gain.
// RULE_12: Exposure priority moves exposure once gain is at maximum.
// RULE_13: Selector picks which region copy the region settings address.
// RULE_14: An enabled region replaces the default measuring area.
// RULE_15: Left offset sets the selected region's left edge.
// RULE_16: Top offset sets the selected region's top edge.
// RULE_17: Spot metering reads a central 3% window.
// RULE_18: Width and height set the selected region's extent.
// RULE_19: One mean and one damped update per frame.
package ae_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_EXP_MIN = 8'h04;
    localparam logic [7:0] OFS_EXP_MAX = 8'h08;
    localparam logic [7:0] OFS_GAIN_MIN = 8'h0C;
    localparam logic [7:0] OFS_GAIN_MAX = 8'h10;
    localparam logic [7:0] OFS_GREY = 8'h14;
    localparam logic [7:0] OFS_BIAS = 8'h18;
    localparam logic [7:0] OFS_DAMP = 8'h1C;
    localparam logic [7:0] OFS_ROI_SEL = 8'h20;
    localparam logic [7:0] OFS_ROI_POS = 8'h24;
    localparam logic [7:0] OFS_ROI_SIZE = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2C;
    localparam logic [7:0] OFS_MEAN = 8'h30;
    // Units: exposure us, gain 0.1 dB, grey percent, damping 1/256.
    localparam logic [19:0] EXP_MIN_RST = 20'h0_0064;
    localparam logic [19:0] EXP_MAX_RST = 20'h0_7530;
    localparam logic [19:0] EXP_FIXED_US = 20'h0_1388;
    localparam logic [9:0] GAIN_MIN_RST = 10'h000;
    localparam logic [9:0] GAIN_MAX_RST = 10'h0F0;
    localparam logic [9:0] GAIN_ZERO_DB = 10'h000;
    localparam logic [6:0] GREY_LO_RST = 7'h0A;
    localparam logic [6:0] GREY_HI_RST = 7'h5A;
    localparam logic [6:0] GREY_TGT_RST = 7'h32;
    localparam logic signed [4:0] BIAS_MIN = -5'sd9;
    localparam logic signed [4:0] BIAS_MAX = 5'sd9;
    localparam logic [8:0] DAMP_RST = 9'h033;
    localparam logic [8:0] DAMP_ONE = 9'h100;
    localparam logic [6:0] GREY_PER_THIRD = 7'h03;
    localparam int CTRL_PRIO_BIT = 0;
    localparam int CTRL_LIGHT_LSB = 1;
    localparam int CTRL_METER_LSB = 3;
    localparam int CTRL_ENABLE_BIT = 5;
    // Window scale in 1/256 of each dimension: sqrt(0.03) and sqrt(0.11).
    localparam logic [8:0] SPOT_SCALE = 9'h02C;
    localparam logic [8:0] PART_SCALE = 9'h055;

    typedef enum logic [1:0] {LIGHT_NORMAL = 2'h0, LIGHT_BACK = 2'h1, LIGHT_FRONT = 2'h2}
        lighting_t;
    typedef enum logic [1:0] {METER_AVG = 2'h0, METER_SPOT = 2'h1, METER_PARTIAL = 2'h2}
        metering_t;
    typedef enum logic {ALG_WB = 1'b0, ALG_AE = 1'b1} alg_sel_t;
    typedef enum logic {PRIO_GAIN = 1'b0, PRIO_EXPOSURE = 1'b1} priority_t;

    typedef struct packed {
        logic use_flag;
        logic [11:0] left;
        logic [11:0] top;
        logic [11:0] width;
        logic [11:0] height;
    } region_t;

    typedef struct packed {
        logic [19:0] exposure_us;
        logic [9:0] gain;
    } sensor_ctl_t;
endpackage

// ---- verification/auto_exposure_checker.sv ----
// Port-level assertion checker of the auto-exposure controller, with its bind.
`timescale 1ns/1ps
module auto_exposure_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Frame and sensor side
    input wire logic frame_end,
    input wire ae_pkg::sensor_ctl_t sensor_ctl,
    input wire logic sensor_update,
    input wire ae_pkg::region_t wb_region
);
    logic [31:0] ctrl, next_ctrl;
    logic [19:0] exp_lo, next_exp_lo, exp_hi, next_exp_hi, exp_fix;
    logic [9:0] gain_lo, next_gain_lo, gain_hi, next_gain_hi, gain_floor;
    logic wr;
    // Shadow limits let the loop outputs be judged from ports alone.
    always_comb begin
        wr = psel && penable && pwrite;
        next_ctrl = (wr && paddr == ae_pkg::OFS_CTRL) ? pwdata : ctrl;
        next_exp_lo = (wr && paddr == ae_pkg::OFS_EXP_MIN) ? pwdata[19:0] : exp_lo;
        next_exp_hi = (wr && paddr == ae_pkg::OFS_EXP_MAX) ? pwdata[19:0] : exp_hi;
        next_gain_lo = (wr && paddr == ae_pkg::OFS_GAIN_MIN) ? pwdata[9:0] : gain_lo;
        next_gain_hi = (wr && paddr == ae_pkg::OFS_GAIN_MAX) ? pwdata[9:0] : gain_hi;
        exp_fix = (ae_pkg::EXP_FIXED_US < exp_lo) ? exp_lo :
            ((ae_pkg::EXP_FIXED_US > exp_hi) ? exp_hi : ae_pkg::EXP_FIXED_US);
        gain_floor = (gain_lo > ae_pkg::GAIN_ZERO_DB) ? gain_lo : ae_pkg::GAIN_ZERO_DB;
    end
    always_ff @(posedge core_clk) begin
        ctrl <= sys_rst ? 32'h0 : next_ctrl;
        exp_lo <= sys_rst ? ae_pkg::EXP_MIN_RST : next_exp_lo;
        exp_hi <= sys_rst ? ae_pkg::EXP_MAX_RST : next_exp_hi;
        gain_lo <= sys_rst ? ae_pkg::GAIN_MIN_RST : next_gain_lo;
        gain_hi <= sys_rst ? ae_pkg::GAIN_MAX_RST : next_gain_hi;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_bad_access;
        psel && penable && (paddr > ae_pkg::OFS_MEAN);
    endsequence
    sequence s_close_enabled;
        frame_end && ctrl[ae_pkg::CTRL_ENABLE_BIT];
    endsequence
    a_ready_high: assert property (pready) else $error("pready low");
    a_bad_err: assert property (s_bad_access |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_good_ok: assert property (psel && penable && paddr <= ae_pkg::OFS_MEAN
        && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access refused");
    a_update_after: assert property (s_close_enabled |=> sensor_update)
        else $error("no update after frame end");
    a_update_cause: assert property (sensor_update |-> $past(frame_end) && !$past(sensor_update))
        else $error("update without frame end");
    a_exp_limits: assert property (sensor_update |-> sensor_ctl.exposure_us >= exp_lo
        && sensor_ctl.exposure_us <= exp_hi) else $error("exposure outside limits");
    a_gain_limits: assert property (sensor_update |-> sensor_ctl.gain >= gain_lo
        && sensor_ctl.gain <= gain_hi) else $error("gain outside limits");
    a_gain_prio: assert property (sensor_update && !ctrl[0] && sensor_ctl.exposure_us < exp_hi
        |-> sensor_ctl.gain == gain_floor) else $error("gain moved early");
    a_exp_prio: assert property (sensor_update && ctrl[0] && sensor_ctl.gain < gain_hi
        |-> sensor_ctl.exposure_us == exp_fix) else $error("exposure moved early");
    a_wb_write: assert property ($changed(wb_region) |-> $past(wr))
        else $error("white balance region changed without write");
endmodule
bind auto_exposure_control auto_exposure_checker i_auto_exposure_checker (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_end(frame_end), .sensor_ctl(sensor_ctl), .sensor_update(sensor_update),
    .wb_region(wb_region));

// ---- verification/tb.sv ----
// Self-checking testbench of the auto-exposure controller.
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [31:0] data;
        logic err;
    } row_t;
    logic core_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pix_valid = 1'h0;
    logic [7:0] pix_data = 8'h00;
    logic [11:0] pix_x = 12'h000;
    logic [11:0] pix_y = 12'h000;
    logic frame_end = 1'h0;
    ae_pkg::sensor_ctl_t sensor_ctl;
    logic sensor_update;
    ae_pkg::region_t wb_region;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic er;
    logic upd;
    row_t rows [17];
    logic [31:0] mctl [5] = '{32'h0000_0028, 32'h0000_0030, 32'h0000_002A, 32'h0000_0034,
        32'h0000_0020};
    logic [31:0] mwant [5] = '{32'h0000_00C8, 32'h0000_00C8, 32'h0000_0032, 32'h0000_0032,
        32'h0000_0032};
    always #50 core_clk = ~core_clk;
    auto_exposure_control #(.FRAME_W(32), .FRAME_H(32)) i_auto_exposure_control (
        .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pix_valid(pix_valid), .pix_data(pix_data), .pix_x(pix_x),
        .pix_y(pix_y), .frame_end(frame_end), .sensor_ctl(sensor_ctl),
        .sensor_update(sensor_update), .wb_region(wb_region));
    task automatic check(input logic [63:0] got, input logic [63:0] want);
        tests_run++;
        if (got !== want) begin
            miscompares++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    task automatic tally_and_finish();
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic do_reset();
        sys_rst <= 1'h1;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'h0;
    endtask
    // Bright centre square on a dim border, then a frame-end pulse.
    task automatic frame(input logic [7:0] hi, input logic [7:0] lo);
        upd = 1'h0;
        for (int y = 0; y < 32; y++) begin
            for (int x = 0; x < 32; x++) begin
                @(posedge core_clk);
                pix_valid <= 1'h1;
                pix_x <= 12'(x);
                pix_y <= 12'(y);
                pix_data <= (x >= 8 && x < 24 && y >= 8 && y < 24) ? hi : lo;
            end
        end
        @(posedge core_clk);
        pix_valid <= 1'h0;
        frame_end <= 1'h1;
        repeat (4) begin
            @(posedge core_clk);
            frame_end <= 1'h0;
            #1 upd = upd | (sensor_update === 1'h1);
        end
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        rows = '{'{1'h0, ae_pkg::OFS_EXP_MIN, 32'h0000_0064, 1'h0},
            '{1'h0, ae_pkg::OFS_EXP_MAX, 32'h0000_7530, 1'h0},
            '{1'h0, ae_pkg::OFS_GAIN_MIN, 32'h0, 1'h0},
            '{1'h0, ae_pkg::OFS_GAIN_MAX, 32'h0000_00F0, 1'h0},
            '{1'h0, ae_pkg::OFS_GREY, 32'h005A_0A32, 1'h0},
            '{1'h0, ae_pkg::OFS_BIAS, 32'h0, 1'h0},
            '{1'h0, ae_pkg::OFS_DAMP, 32'h0000_0033, 1'h0},
            '{1'h1, ae_pkg::OFS_BIAS, 32'h0000_000C, 1'h0},
            '{1'h0, ae_pkg::OFS_BIAS, 32'h0000_0009, 1'h0},
            '{1'h1, ae_pkg::OFS_BIAS, 32'h0000_0003, 1'h0},
            '{1'h0, ae_pkg::OFS_BIAS, 32'h0000_0003, 1'h0},
            '{1'h1, ae_pkg::OFS_DAMP, 32'h0000_0200, 1'h0},
            '{1'h0, ae_pkg::OFS_DAMP, 32'h0000_0100, 1'h0},
            '{1'h1, ae_pkg::OFS_DAMP, 32'h0000_0080, 1'h0},
            '{1'h0, ae_pkg::OFS_DAMP, 32'h0000_0080, 1'h0},
            '{1'h0, 8'h34, 32'h0, 1'h1},
            '{1'h1, 8'h40, 32'h0000_1234, 1'h1}};
        do_reset();
        // Write rows carry write data and check only the error flag.
        for (int i = 0; i < 17; i++) begin
            apb(rows[i].wr, rows[i].addr, rows[i].data);
            check(64'({rows[i].wr ? rows[i].data : rd, er}), 64'({rows[i].data, rows[i].err}));
        end
        apb(1'h1, ae_pkg::OFS_ROI_SEL, 32'h0);
        apb(1'h1, ae_pkg::OFS_ROI_POS, 32'h0020_0010);
        apb(1'h1, ae_pkg::OFS_ROI_SIZE, 32'h0030_0040);
        apb(1'h1, ae_pkg::OFS_ROI_SEL, 32'h0000_0100);
        @(posedge core_clk);
        check(64'(wb_region), 64'({1'h1, 12'h010, 12'h020, 12'h040, 12'h030}));
        apb(1'h1, ae_pkg::OFS_ROI_SEL, 32'h0000_0001);
        apb(1'h1, ae_pkg::OFS_ROI_POS, 32'h0);
        apb(1'h1, ae_pkg::OFS_ROI_SIZE, 32'h0008_0008);
        apb(1'h1, ae_pkg::OFS_ROI_SEL, 32'h0000_0101);
        check(64'(wb_region), 64'({1'h1, 12'h010, 12'h020, 12'h040, 12'h030}));
        apb(1'h0, ae_pkg::OFS_ROI_POS, 32'h0);
        check(64'(rd), 64'h0);
        apb(1'h1, ae_pkg::OFS_CTRL, 32'h0000_0028);
        frame(8'hC8, 8'h00);
        apb(1'h0, ae_pkg::OFS_MEAN, 32'h0);
        check(64'(rd), 64'h0);
        apb(1'h1, ae_pkg::OFS_ROI_SEL, 32'h0000_0001);
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, ae_pkg::OFS_CTRL, mctl[i]);
            frame(8'hC8, 8'h00);
            apb(1'h0, ae_pkg::OFS_MEAN, 32'h0);
            check(64'({rd, upd}), 64'({mwant[i], 1'h1}));
        end
        apb(1'h1, ae_pkg::OFS_CTRL, 32'h0000_0008);
        frame(8'hC8, 8'h00);
        check(64'(upd), 64'h0);
        // Dark frames in gain priority: exposure must saturate before gain moves.
        apb(1'h1, ae_pkg::OFS_CTRL, 32'h0000_0020);
        for (int i = 0; i < 25 && !(rd[0] === 1'h1 && sensor_ctl.gain > 10'h000); i++) begin
            frame(8'h00, 8'h00);
            apb(1'h0, ae_pkg::OFS_STATUS, 32'h0);
        end
        check(64'({sensor_ctl.exposure_us, rd[0], sensor_ctl.gain > 10'h000}),
            64'({ae_pkg::EXP_MAX_RST, 2'h3}));
        do_reset();
        repeat (2) @(posedge core_clk);
        apb(1'h0, ae_pkg::OFS_BIAS, 32'h0);
        check(64'({sensor_ctl, rd}), 64'({ae_pkg::EXP_FIXED_US, ae_pkg::GAIN_ZERO_DB, 32'h0}));
        apb(1'h1, ae_pkg::OFS_CTRL, 32'h0000_0021);
        frame(8'h00, 8'h00);
        check(64'(sensor_ctl.exposure_us), 64'(ae_pkg::EXP_FIXED_US));
        for (int i = 0; i < 25 && sensor_ctl.exposure_us === ae_pkg::EXP_FIXED_US; i++) begin
            frame(8'h00, 8'h00);
        end
        check(64'({sensor_ctl.gain, sensor_ctl.exposure_us > ae_pkg::EXP_FIXED_US}),
            64'({ae_pkg::GAIN_MAX_RST, 1'h1}));
        tally_and_finish();
    end
endmodule
